// ==== design/add_exec.sv ====
// execution logic for the two add instructions of an 8-bit core, with an axi4-lite register port
// assumes the decoder holds instr_word while instr_valid is high and memory answers one cycle after rd
`timescale 1ns/1ns
module add_exec (
  input wire logic clock,                                  // 20 MHz core clock
  input wire logic sys_rst,                                // synchronous reset, active high
  input wire logic instr_valid,                            // decoder offers an instruction
  input wire logic [15:0] instr_word,                      // instruction word
  output logic instr_ready,                                // block takes an instruction
  output logic instr_done,                                 // pulse in the cycle after the write-back phase
  output add_exec_pkg::mem_req_t mem_req,                  // data memory request
  input wire logic [7:0] mem_rd_data,                      // read data, one cycle after rd
  output logic [7:0] acc_out,                              // accumulator
  output add_exec_pkg::flags_t flags_out,                  // status flags
  input wire logic awvalid,                                // axi write address valid
  output logic awready,                                    // axi write address ready
  input wire logic [add_exec_pkg::ADDR_W-1:0] awaddr,      // axi write address
  input wire logic wvalid,                                 // axi write data valid
  output logic wready,                                     // axi write data ready
  input wire logic [31:0] wdata,                           // axi write data
  input wire logic [3:0] wstrb,                            // axi write strobes
  output logic bvalid,                                     // axi write response valid
  input wire logic bready,                                 // axi write response ready
  output logic [1:0] bresp,                                // axi write response
  input wire logic arvalid,                                // axi read address valid
  output logic arready,                                    // axi read address ready
  input wire logic [add_exec_pkg::ADDR_W-1:0] araddr,      // axi read address
  output logic rvalid,                                     // axi read data valid
  input wire logic rready,                                 // axi read data ready
  output logic [31:0] rdata,                               // axi read data
  output logic [1:0] rresp                                 // axi read response
);

  // ======================================================================
  // state
  typedef struct packed {
    add_exec_pkg::phase_t phase;
    logic is_file;
    logic dest;
    logic [7:0] literal;
    logic [7:0] operand;
    logic [7:0] result;
    add_exec_pkg::flags_t new_flags;
    logic [7:0] acc;
    add_exec_pkg::flags_t flags;
    logic enable;
    logic bad_op;
    logic [15:0] add_count;
    add_exec_pkg::mem_req_t mem;
    logic instr_ready;
    logic done;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [add_exec_pkg::ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // slave channels leave reset ready; the instruction port opens one edge later
  localparam state_t ST_RST = '{
    phase: add_exec_pkg::PH_IDLE, is_file: 1'b0, dest: 1'b0, literal: 8'h00, operand: 8'h00,
    result: 8'h00, new_flags: add_exec_pkg::FLAGS_RST, acc: add_exec_pkg::ACC_RST,
    flags: add_exec_pkg::FLAGS_RST, enable: add_exec_pkg::CTRL_EN_RST, bad_op: 1'b0,
    add_count: add_exec_pkg::COUNT_RST, mem: '0, instr_ready: 1'b0, done: 1'b0,
    awready: 1'b1, wready: 1'b1, aw_have: 1'b0, w_have: 1'b0, awaddr: 8'h00, wdata: 8'h00,
    wstrb0: 1'b0, bvalid: 1'b0, bresp: add_exec_pkg::RESP_OKAY, arready: 1'b1, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: add_exec_pkg::RESP_OKAY};

  // ======================================================================
  // helpers
  // opcode decoders are functions so that every caller sees the same field layout
  function automatic logic is_add_lit(input logic [15:0] w);
    is_add_lit = (w[15:add_exec_pkg::LIT_OPC_LSB] == add_exec_pkg::OPC_ADD_LIT);
  endfunction

  function automatic logic is_add_file(input logic [15:0] w);
    is_add_file = (w[15:add_exec_pkg::FILE_OPC_LSB] == add_exec_pkg::OPC_ADD_FILE);
  endfunction

  function automatic logic addr_mapped(input logic [add_exec_pkg::ADDR_W-1:0] a);
    addr_mapped = (a == add_exec_pkg::CTRL_OFS) || (a == add_exec_pkg::ACC_OFS) ||
                  (a == add_exec_pkg::FLAGS_OFS) || (a == add_exec_pkg::INFO_OFS) ||
                  (a == add_exec_pkg::COUNT_OFS);
  endfunction

  // ======================================================================
  // adder and flags, shared by both instructions
  logic [8:0] sum9;
  logic [4:0] nib5;
  add_exec_pkg::flags_t sum_flags;

  always_comb begin
    // operand is latched in Q2, so both inputs stand still through Q3
    sum9 = {1'b0, st_r.acc} + {1'b0, st_r.operand};
    nib5 = {1'b0, st_r.acc[3:0]} + {1'b0, st_r.operand[3:0]};
    sum_flags.c = sum9[8];
    sum_flags.nibble_carry_flag = nib5[4];
    sum_flags.z = (sum9[7:0] == 8'h00);
    sum_flags.n = sum9[7];
    // two like signs giving the other sign is a signed wrap
    sum_flags.signed_wrap_flag = (st_r.acc[7] == st_r.operand[7]) && (sum9[7] != st_r.acc[7]);
  end

  // ======================================================================
  // next state
  logic busy;
  logic sw_write;
  logic bad_set;
  logic [31:0] rd_word;

  always_comb begin
    st_nxt = st_r;
    busy = (st_r.phase != add_exec_pkg::PH_IDLE);
    st_nxt.done = 1'b0;
    bad_set = 1'b0;

    // ---- instruction sequence, one phase per clock ----
    case (st_r.phase)
      add_exec_pkg::PH_IDLE: begin
        if (instr_valid && st_r.instr_ready) begin
          st_nxt.instr_ready = 1'b0;
          if (is_add_lit(instr_word)) begin
            st_nxt.phase = add_exec_pkg::PH_Q1;
            st_nxt.is_file = 1'b0;
            st_nxt.dest = add_exec_pkg::DEST_ACC;
            st_nxt.literal = instr_word[7:0];
          end else if (is_add_file(instr_word)) begin
            st_nxt.phase = add_exec_pkg::PH_Q1;
            st_nxt.is_file = 1'b1;
            st_nxt.dest = instr_word[add_exec_pkg::DEST_BIT];
            st_nxt.mem.rd = 1'b1;
            st_nxt.mem.bank = instr_word[add_exec_pkg::BANK_BIT];
            st_nxt.mem.addr = instr_word[7:0];
          end else begin
            // not ours: flagged and dropped, the decoder must route it elsewhere
            st_nxt.bad_op = 1'b1;
            bad_set = 1'b1;
            st_nxt.instr_ready = st_r.enable;
          end
        end else begin
          st_nxt.instr_ready = st_r.enable;
        end
      end
      add_exec_pkg::PH_Q1: begin
        // memory sees the read in this cycle and answers in the next
        st_nxt.mem.rd = 1'b0;
        st_nxt.phase = add_exec_pkg::PH_Q2;
      end
      add_exec_pkg::PH_Q2: begin
        st_nxt.operand = st_r.is_file ? mem_rd_data : st_r.literal;
        st_nxt.phase = add_exec_pkg::PH_Q3;
      end
      add_exec_pkg::PH_Q3: begin
        // a register destination's write request is raised for Q4, so it lands at the same edge as the accumulator slot
        st_nxt.result = sum9[7:0];
        st_nxt.new_flags = sum_flags;
        if (st_r.is_file && st_r.dest == add_exec_pkg::DEST_FILE) begin
          st_nxt.mem.wr = 1'b1;
          st_nxt.mem.wdata = sum9[7:0];
        end
        st_nxt.phase = add_exec_pkg::PH_Q4;
      end
      add_exec_pkg::PH_Q4: begin
        // write-back: accumulator, flags and the done pulse land at one edge
        st_nxt.mem.wr = 1'b0;
        if (st_r.dest == add_exec_pkg::DEST_ACC) begin
          st_nxt.acc = st_r.result;
        end
        st_nxt.flags = st_r.new_flags;
        st_nxt.add_count = st_r.add_count + 16'h0001;
        st_nxt.done = 1'b1;
        st_nxt.phase = add_exec_pkg::PH_IDLE;
        st_nxt.instr_ready = st_r.enable;
      end
      default: begin
        st_nxt.phase = add_exec_pkg::PH_IDLE;
        st_nxt.mem = '0;
      end
    endcase

    // ---- axi write channel ----
    // address and data are latched apart so either may come first; the answer waits for both
    if (awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awready = 1'b0;
      st_nxt.awaddr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wready = 1'b0;
      st_nxt.wdata = wdata[7:0];
      st_nxt.wstrb0 = wstrb[0];
    end
    sw_write = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    if (sw_write) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = addr_mapped(st_r.awaddr) ? add_exec_pkg::RESP_OKAY : add_exec_pkg::RESP_SLVERR;
      if (st_r.wstrb0) begin
        case (st_r.awaddr)
          add_exec_pkg::CTRL_OFS: begin
            st_nxt.enable = st_r.wdata[add_exec_pkg::CTRL_EN_BIT];
          end
          // accumulator and flags belong to the sequence while it runs; late writes are dropped
          add_exec_pkg::ACC_OFS: begin
            if (!busy) begin
              st_nxt.acc = st_r.wdata;
            end
          end
          add_exec_pkg::FLAGS_OFS: begin
            if (!busy) begin
              st_nxt.flags = st_r.wdata[4:0];
            end
          end
          add_exec_pkg::INFO_OFS: begin
            // a bad opcode seen in this same cycle keeps the bit set
            if (st_r.wdata[add_exec_pkg::INFO_BAD_BIT] && !bad_set) begin
              st_nxt.bad_op = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end

    // ---- axi read channel ----
    // read data is captured at the address handshake and held until rready
    rd_word = 32'h0000_0000;
    case (araddr)
      add_exec_pkg::CTRL_OFS: rd_word[add_exec_pkg::CTRL_EN_BIT] = st_r.enable;
      add_exec_pkg::ACC_OFS: rd_word[7:0] = st_r.acc;
      add_exec_pkg::FLAGS_OFS: rd_word[4:0] = st_r.flags;
      add_exec_pkg::INFO_OFS: begin
        rd_word[add_exec_pkg::INFO_BUSY_BIT] = busy;
        rd_word[add_exec_pkg::INFO_BAD_BIT] = st_r.bad_op;
      end
      add_exec_pkg::COUNT_OFS: rd_word[15:0] = st_r.add_count;
      default: rd_word = 32'h0000_0000;
    endcase
    if (arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = addr_mapped(araddr) ? add_exec_pkg::RESP_OKAY : add_exec_pkg::RESP_SLVERR;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  // ======================================================================
  // registers
  // synchronous reset returns the whole state struct at once
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ======================================================================
  // outputs, all straight from the state register
  assign instr_ready = st_r.instr_ready;
  assign instr_done = st_r.done;
  assign mem_req = st_r.mem;
  assign acc_out = st_r.acc;
  assign flags_out = st_r.flags;
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

endmodule

// ==== design/add_exec_pkg.sv ====
// package for the add execution block: register map, field layout, reset values, states, carriers
// assumes a 32-bit axi4-lite master and an 8-bit data memory with one-cycle read latency
package add_exec_pkg;

  // ======================================================================
  // opcode fields
  localparam logic [7:0] OPC_ADD_LIT = 8'h0f;          // 0000 1111 kkkk kkkk
  localparam logic [5:0] OPC_ADD_FILE = 6'h09;         // 0010 01da ffff ffff
  localparam int LIT_OPC_LSB = 8;
  localparam int FILE_OPC_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // ======================================================================
  // register map (byte addresses) and fields
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;      // bit0 enable
  localparam logic [ADDR_W-1:0] ACC_OFS = 8'h04;       // accumulator, bits 7:0
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h08;     // flags, bits 4:0
  localparam logic [ADDR_W-1:0] INFO_OFS = 8'h0c;      // bit0 busy (ro), bit1 bad opcode (w1c)
  localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h10;     // completed adds, bits 15:0 (ro)
  localparam int CTRL_EN_BIT = 0;
  localparam int INFO_BUSY_BIT = 0;
  localparam int INFO_BAD_BIT = 1;
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_DC_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OV_BIT = 3;
  localparam int FLAG_N_BIT = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ======================================================================
  // reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // ======================================================================
  // types
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1 = 3'b001,
    PH_Q2 = 3'b010,
    PH_Q3 = 3'b011,
    PH_Q4 = 3'b100
  } phase_t;

  typedef struct packed {
    logic n;
    logic signed_wrap_flag;
    logic z;
    logic nibble_carry_flag;
    logic c;
  } flags_t;

  localparam flags_t FLAGS_RST = '{n: 1'b0, signed_wrap_flag: 1'b0, z: 1'b0, nibble_carry_flag: 1'b0, c: 1'b0};

  typedef struct packed {
    logic rd;
    logic wr;
    logic bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

endpackage

// ==== test/add_exec_asserts.sv ====
// checker for the add execution block, watching its instruction and memory ports
// assumes one clock domain and a one-cycle memory read answer
`timescale 1ns/1ns
module add_exec_asserts (
  input wire logic clock, // core clock
  input wire logic sys_rst, // sync reset
  input wire logic instr_valid, // offer
  input wire logic [15:0] instr_word, // word
  input wire logic instr_ready, // take
  input wire logic instr_done, // done pulse
  input wire add_exec_pkg::mem_req_t mem_req, // memory request
  input wire logic [7:0] mem_rd_data, // memory answer
  input wire logic [7:0] acc_out, // accumulator
  input wire add_exec_pkg::flags_t flags_out // flags
);
  // ==========================================
  // decode of the taking edge
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic tk, lit, fil;
  assign tk = instr_valid && instr_ready;
  assign lit = tk && instr_word[15:8] == add_exec_pkg::OPC_ADD_LIT;
  assign fil = tk && instr_word[15:10] == add_exec_pkg::OPC_ADD_FILE;
  // ==========================================
  // assertions
  lit_acc_sum_a: assert property (lit |-> ##5
    acc_out == 8'($past(acc_out, 5) + $past(instr_word[7:0], 5)))
    else $error("literal add sum wrong");
  file_read_a: assert property (fil |=> mem_req.rd && mem_req.addr == $past(instr_word[7:0]))
    else $error("file add read request wrong");
  file_acc_a: assert property (fil && !instr_word[9] |-> ##5
    acc_out == 8'($past(acc_out, 5) + $past(mem_rd_data, 3)))
    else $error("file add to accumulator wrong");
  file_keep_a: assert property (fil && !instr_word[9] |-> !mem_req.wr [*6])
    else $error("register written with accumulator destination");
  file_wb_a: assert property (fil && instr_word[9] |-> ##4 mem_req.wr &&
    mem_req.wdata == 8'($past(acc_out, 4) + $past(mem_rd_data, 2)) ##1 acc_out == $past(acc_out, 5))
    else $error("file add write back wrong");
  done_time_a: assert property ((lit || fil) |=> !instr_done [*4] ##1 instr_done)
    else $error("done pulse at wrong cycle");
  busy_span_a: assert property ((lit || fil) |=> !instr_ready [*4] ##1 instr_ready)
    else $error("ready wrong during instruction");
  lit_flags_a: assert property (lit |-> ##5
    flags_out.n == acc_out[7] && flags_out.z == (acc_out == 8'h00) &&
    flags_out.c == (9'($past(acc_out, 5)) + 9'($past(instr_word[7:0], 5)) > 9'h0ff))
    else $error("literal add flags wrong");
  cover property (lit);
  cover property (fil && instr_word[9]);
  cover property (fil && !instr_word[9]);
endmodule
bind add_exec add_exec_asserts chk_u (.clock, .sys_rst, .instr_valid, .instr_word, .instr_ready,
  .instr_done, .mem_req, .mem_rd_data, .acc_out, .flags_out);

// ==== test/data_mem_model.sv ====
// data memory standing beside the add block
// assumes reads are answered in the cycle after rd and writes land at the edge
`timescale 1ns/1ns
module data_mem_model (
  input wire logic clock, // core clock
  input wire add_exec_pkg::mem_req_t mem_req, // request
  output logic [7:0] mem_rd_data // answer
);
  logic [7:0] mem [256];
  always @(posedge clock) begin
    if (mem_req.rd) begin
      mem_rd_data <= mem[mem_req.addr];
    end else begin
      mem_rd_data <= ~mem_rd_data; // stale data must never pass for an answer
    end
    if (mem_req.wr) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule

// ==== test/add_instruction_execution_tb_top.sv ====
// testbench for the add execution block: register port, literal and file adds
// assumes the package constants and a one-cycle data memory model
`timescale 1ns/1ns
module add_instruction_execution_tb_top;
  logic clock = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_ready, instr_done, awready, wready, bvalid, arready, rvalid, dn;
  add_exec_pkg::mem_req_t mem_req;
  add_exec_pkg::flags_t flags_out;
  logic [7:0] mem_rd_data, acc_out, awaddr = 8'h00, araddr = 8'h00, s;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic [7:0] ta [5] = '{8'h10, 8'hff, 8'h7f, 8'h08, 8'h80};
  logic [7:0] tk [5] = '{8'h15, 8'h01, 8'h01, 8'h08, 8'h80};
  int bad_count = 0, tests_run = 0;
  add_exec dut_u (.clock, .sys_rst, .instr_valid, .instr_word, .instr_ready, .instr_done, .mem_req,
    .mem_rd_data, .acc_out, .flags_out, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  data_mem_model pm_u (.clock, .mem_req, .mem_rd_data);
  initial forever #25 clock = ~clock;
  // ==========================================
  // tasks
  function automatic logic [4:0] flg(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = 9'(a) + 9'(b);
    return {t[7], a[7] == b[7] && t[7] != a[7], t[7:0] == 8'h00, 5'(a[3:0]) + 5'(b[3:0]) > 5'h0f, t[8]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic qa, qw, qb;
    @(posedge clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    qb = 1'b0;
    while (!qb) begin
      @(negedge clock);
      qa = awready && awvalid;
      qw = wready && wvalid;
      qb = bvalid;
      rsp = bresp;
      @(posedge clock);
      if (qa) awvalid <= 1'b0;
      if (qw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    logic qa, qr;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    qr = 1'b0;
    while (!qr) begin
      @(negedge clock);
      qa = arready && arvalid;
      qr = rvalid;
      d = rdata;
      rsp = rresp;
      @(posedge clock);
      if (qa) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // done is looked at in the fifth cycle after the taking edge, as the hand-over fixes
  task automatic exec(input logic [15:0] w, output logic d);
    logic q;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    q = 1'b0;
    while (!q) begin
      @(negedge clock);
      q = instr_ready;
      @(posedge clock);
    end
    instr_valid <= 1'b0;
    repeat (5) @(negedge clock);
    d = instr_done;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    pm_u.mem[8'h30] = 8'hc2;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    axi_rd(add_exec_pkg::CTRL_OFS, v, r);
    chk(v, 32'h1);
    axi_rd(add_exec_pkg::ACC_OFS, v, r);
    chk(v, 32'h0);
    axi_rd(8'h40, v, r);
    chk(r, add_exec_pkg::RESP_SLVERR);
    axi_wr(8'h40, 32'h1, r);
    chk(r, add_exec_pkg::RESP_SLVERR);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      axi_wr(add_exec_pkg::ACC_OFS, 32'(ta[i]), r);
      exec({add_exec_pkg::OPC_ADD_LIT, tk[i]}, dn);
      s = ta[i] + tk[i];
      chk(dn, 32'h1);
      chk(acc_out, s);
      chk(flags_out, flg(ta[i], tk[i]));
    end
    axi_rd(add_exec_pkg::FLAGS_OFS, v, r);
    chk(v, 32'(flg(8'h80, 8'h80)));
    $display("literal test done");
    axi_wr(add_exec_pkg::ACC_OFS, 32'h17, r);
    exec({add_exec_pkg::OPC_ADD_FILE, add_exec_pkg::DEST_ACC, 1'b0, 8'h30}, dn);
    chk(acc_out, 32'hd9);
    chk(pm_u.mem[8'h30], 32'hc2);
    chk(flags_out, flg(8'h17, 8'hc2));
    axi_wr(add_exec_pkg::ACC_OFS, 32'h05, r);
    exec({add_exec_pkg::OPC_ADD_FILE, add_exec_pkg::DEST_FILE, 1'b1, 8'h30}, dn);
    chk(pm_u.mem[8'h30], 32'hc7);
    chk(acc_out, 32'h05);
    chk(dn, 32'h1);
    $display("file test done");
    exec(16'h0b00, dn);
    axi_rd(add_exec_pkg::INFO_OFS, v, r);
    chk(v[1], 32'h1);
    axi_wr(add_exec_pkg::INFO_OFS, 32'h2, r);
    axi_rd(add_exec_pkg::INFO_OFS, v, r);
    chk(v[1], 32'h0);
    $display("bad opcode test done");
    axi_rd(add_exec_pkg::COUNT_OFS, v, r);
    chk(v, 32'h7);
    axi_wr(add_exec_pkg::CTRL_OFS, 32'h0, r);
    @(negedge clock);
    chk(instr_ready, 32'h0);
    axi_wr(add_exec_pkg::CTRL_OFS, 32'h1, r);
    @(negedge clock);
    chk(instr_ready, 32'h1);
    $display("control test done");
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    axi_rd(add_exec_pkg::COUNT_OFS, v, r);
    chk(v, 32'h0);
    axi_rd(add_exec_pkg::ACC_OFS, v, r);
    chk(v, 32'h0);
    $display("reset test done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize();
  end
endmodule
